// file: design/gtm_pkg.sv
// Package: register map, control fields and state carriers of the 16-bit timer
package gtm_pkg;

  // ==========================================================================
  // Register indices and byte addresses (byte address is four times the index)
  // ==========================================================================
  localparam logic [11:0] GTM_IDX_COUNT   = 12'h100;
  localparam logic [11:0] GTM_IDX_PERIOD  = 12'h102;
  localparam logic [11:0] GTM_IDX_CONTROL = 12'h104;
  localparam logic [11:0] GTM_IDX_STATUS  = 12'h106;
  localparam logic [13:0] GTM_ADDR_COUNT   = {GTM_IDX_COUNT, 2'b00};
  localparam logic [13:0] GTM_ADDR_PERIOD  = {GTM_IDX_PERIOD, 2'b00};
  localparam logic [13:0] GTM_ADDR_CONTROL = {GTM_IDX_CONTROL, 2'b00};
  localparam logic [13:0] GTM_ADDR_STATUS  = {GTM_IDX_STATUS, 2'b00};

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] GTM_RST_COUNT  = 16'h0000;
  localparam logic [15:0] GTM_RST_PERIOD = 16'hffff;

  // ==========================================================================
  // Control field positions
  // ==========================================================================
  localparam int GTM_BIT_TIMER_ON    = 15;
  localparam int GTM_BIT_STOP_IDLE   = 13;
  localparam int GTM_BIT_GATE        = 6;
  localparam int GTM_BIT_PRESCALE_HI = 5;
  localparam int GTM_BIT_PRESCALE_LO = 4;
  localparam int GTM_BIT_EXT_SYNC    = 2;
  localparam int GTM_BIT_CLK_SRC     = 1;
  localparam int GTM_BIT_FLAG        = 0;

  // ==========================================================================
  // Prescaler encodings and terminal counts (divide ratio minus one)
  // ==========================================================================
  localparam logic [1:0] GTM_PS_DIV1   = 2'h0;
  localparam logic [1:0] GTM_PS_DIV8   = 2'h1;
  localparam logic [1:0] GTM_PS_DIV64  = 2'h2;
  localparam logic [1:0] GTM_PS_DIV256 = 2'h3;
  localparam logic [7:0] GTM_TERM_DIV1   = 8'h00;
  localparam logic [7:0] GTM_TERM_DIV8   = 8'h07;
  localparam logic [7:0] GTM_TERM_DIV64  = 8'h3f;
  localparam logic [7:0] GTM_TERM_DIV256 = 8'hff;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       timer_on;
    logic       stop_in_idle;
    logic       gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic       external_sync_select;
    logic       clock_source_select;
  } gtm_ctrl_s;

  typedef struct packed {
    gtm_ctrl_s   ctrl;
    logic [15:0] count_value;
    logic [15:0] period_value;
    logic        period_interrupt_flag;
    logic        timer_event;
    logic        gate_prev;
    logic        ext_prev;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } gtm_state_s;

  typedef struct packed {
    logic [7:0] div_cnt;
  } gtm_ps_state_s;

endpackage : gtm_pkg

// file: design/gtm_sync.sv
// Two flip-flop synchroniser for the external clock / gate pin
`timescale 1ns/10ps
`default_nettype none
module gtm_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta_reg;

  // ==========================================================================
  // First stage is read only by the second stage
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : gtm_sync
`default_nettype wire

// file: design/gtm_prescaler.sv
// Prescaler: divides the selected tick stream by 1, 8, 64 or 256
`timescale 1ns/10ps
`default_nettype none
module gtm_prescaler
  import gtm_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [1:0] prescale_select,
  output logic            inc
);
  gtm_ps_state_s state_reg;
  gtm_ps_state_s state_next;
  logic [7:0]    term;

  // ==========================================================================
  // Terminal count per prescale code
  // ==========================================================================
  always_comb begin
    case (prescale_select)
      GTM_PS_DIV1:   term = GTM_TERM_DIV1;
      GTM_PS_DIV8:   term = GTM_TERM_DIV8;
      GTM_PS_DIV64:  term = GTM_TERM_DIV64;
      GTM_PS_DIV256: term = GTM_TERM_DIV256;
      default:       term = GTM_TERM_DIV1;
    endcase
  end

  // Output pulse on the tick that completes a division
  assign inc = tick && (state_reg.div_cnt >= term);

  // ==========================================================================
  // Divide counter; clear wins over counting
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    if (clear) begin
      state_next.div_cnt = 8'h00;
    end else if (inc) begin
      state_next.div_cnt = 8'h00;
    end else if (tick) begin
      state_next.div_cnt = state_reg.div_cnt + 8'h01;
    end
  end

  // Device reset clears the divide counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : gtm_prescaler
`default_nettype wire

// file: design/gtm_timer.sv
// Top of the 16-bit gated, prescaled timer with its APB register slave
//
// Functional notes
// - Timer mode: count advances each instruction cycle, wraps to zero after period match.
// - Synchronous counter: count advances on resynchronised external rising edges, wraps.
// - Asynchronous counter: count advances on external rising edges, wraps after period.
// - Timer, sync and gated modes halt in idle when stop-in-idle is set.
// - Asynchronous counter mode also halts in idle when stop-in-idle is set.
// - Gated mode counts instruction cycles only while the gate pin is high.
// - Clock source select zero picks the internal instruction clock.
// - Selected clock passes a divide by 1, 8, 64 or 256 prescaler.
// - Prescaler clears on count write, control write and device reset.
// - With timer off, the prescaler is not cleared by those writes.
// - Control writes leave the count alone; only count writes change it.
// - Event raised on period match and on gate falling edge.
// - Period match sets a flag that stays until software clears it.
// - External sync bit zero means asynchronous, one means synchronised counting.
// - In sleep only an enabled, external, asynchronous timer keeps counting.
`timescale 1ns/10ps
`default_nettype none
module gtm_timer
  import gtm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_clock_gate_pin,
  input  wire logic        cpu_idle,
  input  wire logic        cpu_sleep,
  output logic             period_interrupt_flag,
  output logic             timer_event
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  gtm_state_s  state_reg;
  gtm_state_s  state_next;
  logic        pin_sync;
  logic        setup_phase;
  logic        access_wr;
  logic        wr_count;
  logic        wr_period;
  logic        wr_control;
  logic        wr_status;
  logic        addr_hit;
  logic        ext_rise;
  logic        gate_fall;
  logic        async_mode;
  logic        gated_mode;
  logic        halted;
  logic        tick;
  logic        ps_clear;
  logic        inc;
  logic        match;
  logic [31:0] rd_word;

  // ==========================================================================
  // Pin input: two flip-flops before any logic reads it
  // ==========================================================================
  gtm_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_clock_gate_pin),
    .sync_out (pin_sync)
  );

  // ==========================================================================
  // APB decode
  // ==========================================================================
  // A write lands only at the access edge that sees pready high
  assign setup_phase = psel && !penable;
  assign access_wr   = psel && penable && pready && pwrite && !pslverr;
  assign wr_count    = access_wr && (paddr[13:0] == GTM_ADDR_COUNT);
  assign wr_period   = access_wr && (paddr[13:0] == GTM_ADDR_PERIOD);
  assign wr_control  = access_wr && (paddr[13:0] == GTM_ADDR_CONTROL);
  assign wr_status   = access_wr && (paddr[13:0] == GTM_ADDR_STATUS);

  // Address check used at the setup cycle to decide the error answer
  always_comb begin
    case (paddr[13:0])
      GTM_ADDR_COUNT,
      GTM_ADDR_PERIOD,
      GTM_ADDR_CONTROL,
      GTM_ADDR_STATUS: addr_hit = (paddr[15:14] == 2'b00) && (paddr[1:0] == 2'b00);
      default:         addr_hit = 1'b0;
    endcase
  end

  // Read mux; reserved control bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr[13:0])
      GTM_ADDR_COUNT:  rd_word[15:0] = state_reg.count_value;
      GTM_ADDR_PERIOD: rd_word[15:0] = state_reg.period_value;
      GTM_ADDR_CONTROL: begin
        rd_word[GTM_BIT_TIMER_ON]  = state_reg.ctrl.timer_on;
        rd_word[GTM_BIT_STOP_IDLE] = state_reg.ctrl.stop_in_idle;
        rd_word[GTM_BIT_GATE]      = state_reg.ctrl.gate_accumulate_enable;
        rd_word[GTM_BIT_PRESCALE_HI:GTM_BIT_PRESCALE_LO] = state_reg.ctrl.prescale_select;
        rd_word[GTM_BIT_EXT_SYNC]  = state_reg.ctrl.external_sync_select;
        rd_word[GTM_BIT_CLK_SRC]   = state_reg.ctrl.clock_source_select;
      end
      GTM_ADDR_STATUS: rd_word[GTM_BIT_FLAG] = state_reg.period_interrupt_flag;
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Mode and halt decode
  // ==========================================================================
  // External source with sync bit zero counts asynchronously
  assign async_mode = state_reg.ctrl.clock_source_select &&
                      !state_reg.ctrl.external_sync_select;

  // Gate only applies with the internal source selected
  assign gated_mode = state_reg.ctrl.gate_accumulate_enable &&
                      !state_reg.ctrl.clock_source_select;

  // Idle halts every mode under stop-in-idle; sleep spares only async counting
  always_comb begin
    halted = !state_reg.ctrl.timer_on;
    if (cpu_idle && state_reg.ctrl.stop_in_idle) begin
      halted = 1'b1;
    end
    if (cpu_sleep && !async_mode) begin
      halted = 1'b1;
    end
  end

  // ==========================================================================
  // Tick selection
  // ==========================================================================
  // Edges are taken from the synchronised pin and its registered copy
  assign ext_rise  = pin_sync && !state_reg.ext_prev;
  assign gate_fall = !pin_sync && state_reg.gate_prev;

  // Pin edges in async mode still pass the synchroniser: single clock domain
  always_comb begin
    tick = 1'b0;
    if (!halted) begin
      if (!state_reg.ctrl.clock_source_select) begin
        if (gated_mode) begin
          tick = pin_sync;
        end else begin
          tick = 1'b1;
        end
      end else if (state_reg.ctrl.external_sync_select) begin
        tick = ext_rise;
      end else begin
        tick = ext_rise;
      end
    end
  end

  // Prescaler clock stands still while the timer is off, so no clear then
  assign ps_clear = (wr_count || wr_control) && state_reg.ctrl.timer_on;

  gtm_prescaler u_prescaler (
    .pclk            (pclk),
    .presetn         (presetn),
    .tick            (tick),
    .clear           (ps_clear),
    .prescale_select (state_reg.ctrl.prescale_select),
    .inc             (inc)
  );

  // Match is seen on the increment that finds count equal to period
  assign match = inc && (state_reg.count_value == state_reg.period_value);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_next             = state_reg;
    state_next.timer_event = 1'b0;
    state_next.ext_prev    = pin_sync;
    // Gate history only tracks while gated counting is armed
    if (gated_mode && state_reg.ctrl.timer_on) begin
      state_next.gate_prev = pin_sync;
    end else begin
      state_next.gate_prev = 1'b0;
    end

    // Count: software write has priority over counting
    if (wr_count) begin
      state_next.count_value = pwdata[15:0];
    end else if (match) begin
      state_next.count_value = 16'h0000;
    end else if (inc) begin
      state_next.count_value = state_reg.count_value + 16'h0001;
    end

    if (wr_period) begin
      state_next.period_value = pwdata[15:0];
    end

    // Control write never touches the count
    if (wr_control) begin
      state_next.ctrl.timer_on               = pwdata[GTM_BIT_TIMER_ON];
      state_next.ctrl.stop_in_idle           = pwdata[GTM_BIT_STOP_IDLE];
      state_next.ctrl.gate_accumulate_enable = pwdata[GTM_BIT_GATE];
      state_next.ctrl.prescale_select =
        pwdata[GTM_BIT_PRESCALE_HI:GTM_BIT_PRESCALE_LO];
      state_next.ctrl.external_sync_select   = pwdata[GTM_BIT_EXT_SYNC];
      state_next.ctrl.clock_source_select    = pwdata[GTM_BIT_CLK_SRC];
    end

    // Flag: write one clears, a same-cycle event wins over the clear
    if (wr_status && pwdata[GTM_BIT_FLAG]) begin
      state_next.period_interrupt_flag = 1'b0;
    end
    if (match || (gated_mode && gate_fall)) begin
      state_next.period_interrupt_flag = 1'b1;
      state_next.timer_event           = 1'b1;
    end

    // APB answer is prepared in the setup cycle, no wait states
    state_next.pready  = 1'b0;
    state_next.pslverr = 1'b0;
    if (setup_phase) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !addr_hit;
      state_next.prdata  = (pwrite || !addr_hit) ? 32'h0000_0000 : rd_word;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg              <= '0;
      state_reg.count_value  <= GTM_RST_COUNT;
      state_reg.period_value <= GTM_RST_PERIOD;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs straight from the state register
  // ==========================================================================
  assign prdata                = state_reg.prdata;
  assign pready                = state_reg.pready;
  assign pslverr               = state_reg.pslverr;
  assign period_interrupt_flag = state_reg.period_interrupt_flag;
  assign timer_event           = state_reg.timer_event;

endmodule : gtm_timer
`default_nettype wire

// file: dv/gtm_timer_monitor.sv
// Checker of the timer's bus answers, flag and event outputs
`timescale 1ns/10ps
`default_nettype none
module gtm_timer_monitor
  import gtm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_clock_gate_pin,
  input wire logic        cpu_idle,
  input wire logic        cpu_sleep,
  input wire logic        period_interrupt_flag,
  input wire logic        timer_event
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  logic mapped;
  logic clr_req;
  // Only these four words answer without an error
  assign mapped = paddr == {2'b00, GTM_ADDR_COUNT} || paddr == {2'b00, GTM_ADDR_PERIOD}
               || paddr == {2'b00, GTM_ADDR_CONTROL} || paddr == {2'b00, GTM_ADDR_STATUS};
  // Software clear of the flag takes effect at the access edge
  assign clr_req = psel && penable && pwrite && pwdata[0] && paddr == {2'b00, GTM_ADDR_STATUS};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access phase");
  property p_err_bad; psel && !penable && !mapped |=> pslverr && pready; endproperty
  a_err_bad: assert property (p_err_bad) else $error("unmapped address not refused");
  property p_err_ok; psel && !penable && mapped |=> !pslverr; endproperty
  a_err_ok: assert property (p_err_ok) else $error("mapped address refused");
  property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data on a write");
  property p_evt_flag; timer_event |-> period_interrupt_flag; endproperty
  a_evt_flag: assert property (p_evt_flag) else $error("event without flag");
  property p_flag_rise; $rose(period_interrupt_flag) |-> timer_event; endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set without event");
  property p_flag_keep; period_interrupt_flag && !clr_req |=> period_interrupt_flag; endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost");
endmodule : gtm_timer_monitor
`default_nettype wire

// file: dv/gtm_pin_model.sv
// Model of the external clock or gate source on the timer pin
`timescale 1ns/10ps
`default_nettype none
module gtm_pin_model (
  input  wire logic pclk,
  output var  logic pin
);
  // Pin rests low between bursts, like an idle external source
  initial pin = 1'b0;
  // Burst of n rising edges: high held for half cycles, low for half + 1 cycles between pulses
  task automatic pulses(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk) pin <= 1'b1;
      repeat (half) @(posedge pclk);
      pin <= 1'b0;
      repeat (half) @(posedge pclk);
    end
  endtask : pulses
  // One gate window of exactly len cycles
  task automatic gate(input int len);
    @(posedge pclk) pin <= 1'b1;
    repeat (len) @(posedge pclk);
    pin <= 1'b0;
  endtask : gate
endmodule : gtm_pin_model
`default_nettype wire

// file: dv/gtm_timer_tb_top.sv
// Self-checking bench of the 16-bit gated, prescaled timer
`timescale 1ns/10ps
`default_nettype none
module gtm_timer_tb_top;
  import gtm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        ext_pin, cpu_idle, cpu_sleep, flag, tevt;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  int          mismatches, n_tests, cyc;
  gtm_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_gate_pin(ext_pin), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .period_interrupt_flag(flag), .timer_event(tevt));
  gtm_pin_model u_pin (.pclk(pclk), .pin(ext_pin));
  // ==========================================================================
  // Clock and watchdog
  // ==========================================================================
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;
  // Ceiling well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      results();
    end
  end
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    n_tests++;
    if (got !== want) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h want %h", $time, what, got, want);
    end
  endtask : check
  // One APB transfer; read data and error are taken at the ready edge only
  task automatic apb(input logic w, input logic [13:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, a};
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_evt(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tevt !== 1'b1 && n < 3000);
  endtask : wait_evt
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    apb(0, GTM_ADDR_PERIOD, 16'h0);
    check(rdv, 32'hffff, "period reset");
    apb(0, GTM_ADDR_CONTROL, 16'h0);
    check(rdv, 32'h0, "control reset");
    apb(0, 14'h0004, 16'h0);
    check({31'h0, err}, 32'h1, "unmapped refused");
    apb(1, GTM_ADDR_COUNT, 16'h1234);
    apb(1, GTM_ADDR_CONTROL, 16'h0030);
    repeat (20) @(posedge pclk);
    apb(0, GTM_ADDR_COUNT, 16'h0);
    check(rdv, 32'h1234, "count kept");
  endtask : t_regs
  // Event spacing is (period + 1) times the divide ratio
  task automatic t_period();
    int n;
    int div [4] = '{1, 8, 64, 256};
    for (int ps = 0; ps < 4; ps++) begin
      apb(1, GTM_ADDR_CONTROL, 16'h0);
      apb(1, GTM_ADDR_PERIOD, 16'h0003);
      apb(1, GTM_ADDR_COUNT, 16'h0);
      apb(1, GTM_ADDR_CONTROL, 16'h8000 | (16'(ps) << 4));
      wait_evt(n);
      wait_evt(n);
      check(32'(n), 32'(4 * div[ps]), "event spacing");
    end
    apb(1, GTM_ADDR_CONTROL, 16'h0);
    apb(0, GTM_ADDR_STATUS, 16'h0);
    check(rdv, 32'h1, "flag held");
    apb(1, GTM_ADDR_STATUS, 16'h1);
    apb(0, GTM_ADDR_STATUS, 16'h0);
    check(rdv, 32'h0, "flag cleared");
  endtask : t_period
  // Back-to-back reads are three cycles apart at divide by one
  task automatic t_idle();
    logic [31:0] a;
    logic [15:0] ctl [4] = '{16'ha000, 16'h8000, 16'ha000, 16'h8000};
    logic        idl [4] = '{1, 1, 0, 0};
    logic        slp [4] = '{0, 0, 0, 1};
    logic [31:0] dif [4] = '{0, 3, 3, 0};
    apb(1, GTM_ADDR_PERIOD, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      cpu_idle  <= idl[i];
      cpu_sleep <= slp[i];
      apb(1, GTM_ADDR_CONTROL, ctl[i]);
      apb(0, GTM_ADDR_COUNT, 16'h0);
      a = rdv;
      apb(0, GTM_ADDR_COUNT, 16'h0);
      check(rdv - a, dif[i], "idle or sleep rate");
    end
  endtask : t_idle
  task automatic t_ext();
    logic [15:0] ctl [5] = '{16'h8006, 16'h8002, 16'h8002, 16'h8006, 16'ha002};
    logic        slp [5] = '{0, 0, 1, 1, 0};
    logic        idl [5] = '{0, 0, 0, 0, 1};
    logic [31:0] want [5] = '{5, 5, 5, 0, 0};
    for (int i = 0; i < 5; i++) begin
      apb(1, GTM_ADDR_CONTROL, 16'h0);
      apb(1, GTM_ADDR_COUNT, 16'h0);
      cpu_sleep <= slp[i];
      cpu_idle  <= idl[i];
      apb(1, GTM_ADDR_CONTROL, ctl[i]);
      u_pin.pulses(5, 3);
      repeat (6) @(posedge pclk);
      cpu_sleep <= 1'b0;
      cpu_idle  <= 1'b0;
      apb(1, GTM_ADDR_CONTROL, 16'h0);
      apb(0, GTM_ADDR_COUNT, 16'h0);
      check(rdv, want[i], "external edges");
    end
  endtask : t_ext
  task automatic t_gate();
    int n;
    apb(1, GTM_ADDR_STATUS, 16'h1);
    apb(1, GTM_ADDR_CONTROL, 16'h8040);
    u_pin.gate(20);
    wait_evt(n);
    check({31'h0, n < 10}, 32'h1, "gate fall event");
    apb(0, GTM_ADDR_COUNT, 16'h0);
    check(rdv, 32'd20, "gated count");
    apb(0, GTM_ADDR_STATUS, 16'h0);
    check(rdv, 32'h1, "flag after gate");
    check({31'h0, flag}, 32'h1, "flag output");
  endtask : t_gate
  // Count write while running restarts the divide by eight: first step 8 cycles on
  task automatic t_clear();
    apb(1, GTM_ADDR_CONTROL, 16'h8010);
    apb(1, GTM_ADDR_COUNT, 16'h0000);
    repeat (5) @(posedge pclk);
    apb(0, GTM_ADDR_COUNT, 16'h0000);
    check(rdv, 32'h0000_0000, "prescaler cleared");
    apb(0, GTM_ADDR_COUNT, 16'h0000);
    check(rdv, 32'h0000_0001, "first divided step");
  endtask : t_clear
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, cpu_idle, cpu_sleep} = 6'h0;
    paddr  = 16'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    $display("registers done");
    t_period();
    $display("period done");
    t_idle();
    $display("idle done");
    t_ext();
    $display("external done");
    t_gate();
    $display("gate done");
    t_clear();
    $display("clear done");
    results();
  end
endmodule : gtm_timer_tb_top
bind gtm_timer gtm_timer_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_clock_gate_pin(ext_clock_gate_pin),
  .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .period_interrupt_flag(period_interrupt_flag),
  .timer_event(timer_event));
`default_nettype wire
